// [verilog/setpoint_map.vh]
/*
 * Register map, field layout, reset values and timing counts of the
 * setpoint output updater.
 * Assumes a 100 MHz system clock and 32-bit AXI4-Lite word addressing.
 */
`ifndef SETPOINT_MAP_VH
`define SETPOINT_MAP_VH

// Global registers
`define SP_CTRL_ADDR 9'h000
`define SP_PORT_ADDR 9'h004
`define SP_STAT_ADDR 9'h008
`define SP_TABLE_BASE 9'h100

// Per setpoint: 4 words at base + slot*16 + word*4; table index in addr[7:2]
// Word 0: limit A [15:0], limit B [31:16]
// Word 1: criterion [2:0], mode [5:4], target1 [10:8], target2 [14:12],
//         half select [16]
// Word 2: value 1 [15:0], mask 1 [23:16]
// Word 3: value 2 [15:0], mask 2 [23:16]
`define SP_W_LIMITS 2'h0
`define SP_W_CFG 2'h1
`define SP_W_VAL1 2'h2
`define SP_W_VAL2 2'h3

// Control fields
`define SP_CTRL_RUN 0
`define SP_CTRL_RESET 32'h0000_0000

// Criteria codes
`define SP_CRIT_INSIDE 3'h0
`define SP_CRIT_OUTSIDE 3'h1
`define SP_CRIT_ABOVE 3'h2
`define SP_CRIT_BELOW 3'h3
`define SP_CRIT_EQUAL 3'h4

// Update modes
`define SP_MODE_NONE 2'h0
`define SP_MODE_TRUE 2'h1
`define SP_MODE_TF 2'h2
`define SP_MODE_HYST 2'h3

// Targets
`define SP_TGT_NONE 3'h0
`define SP_TGT_PORT 3'h1
`define SP_TGT_DAC 3'h2
`define SP_TGT_TIMER 3'h3

// Timing
`define SP_CLK_MHZ 100
`define SP_PIPE_US 2
`define SP_DAC_US 3
`define SP_PIPE_CYC (`SP_PIPE_US * `SP_CLK_MHZ)
`define SP_DAC_CYC (`SP_DAC_US * `SP_CLK_MHZ)

`endif

// [verilog/setpoint_cfg_mem.v]
/*
 * Configuration memory of the setpoint table: one write port, two
 * registered read ports (bus readback and evaluation).
 * Assumes a single clock; read data appear one cycle after the address.
 */
`timescale 1ns/100ps
module setpoint_cfg_mem #(
  parameter AW = 6,
  parameter DW = 32
) (
  input wire clk_sys,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr_a,
  output reg [DW-1:0] rd_data_a,
  input wire [AW-1:0] rd_addr_b,
  output reg [DW-1:0] rd_data_b
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write and both registered reads
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end

endmodule

// [verilog/setpoint_output_updater.v]
/*
 * Setpoint output updater: per-sample window detection and driving of
 * the setpoint digital port, analog output channels and timer loads.
 * Assumes acquisition samples arrive tagged with their setpoint slot,
 * one per scan per slot, and all inputs synchronous to clk_sys.
 */
`timescale 1ns/100ps
module setpoint_output_updater #(
  parameter NSP = 16,
  parameter NDAC = 4,
  parameter NTMR = 2
) (
  input wire clk_sys,
  input wire sys_rst,
  // AXI4-Lite slave
  input wire [8:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [8:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Acquisition stream
  input wire scan_start,
  input wire smp_valid,
  input wire [3:0] smp_slot,
  input wire [31:0] smp_data,
  // Setpoint digital port (two-way)
  input wire [7:0] setpoint_digital_port_i,
  output reg [7:0] setpoint_digital_port_o,
  output reg setpoint_digital_port_oe,
  // Analog outputs
  output reg analog_output_channel_we,
  output reg [1:0] analog_output_channel_sel,
  output reg [15:0] analog_output_channel_data,
  output reg analog_output_channel_done,
  // Timers
  output reg timer_load,
  output reg [0:0] timer_sel,
  output reg [15:0] timer_value,
  // Detect vector
  output reg [15:0] detect
);

`include "setpoint_map.vh"

  localparam S_IDLE = 3'd0;
  localparam S_WAIT = 3'd1;
  localparam S_RD0 = 3'd2;
  localparam S_RD1 = 3'd3;
  localparam S_RD2 = 3'd4;
  localparam S_RD3 = 3'd5;
  localparam S_EVAL = 3'd6;

  // Wait end leaves four cycles for the table fetch; analog settle reload
  localparam [8:0] PIPE_LAST = `SP_PIPE_CYC - 4;
  localparam [8:0] DAC_LOAD = `SP_DAC_CYC - 1;

  // ****************************************************
  // Functions
  // ****************************************************
  function crit_met;
    input [2:0] crit;
    input [15:0] x;
    input [15:0] la;
    input [15:0] lb;
    begin
      case (crit)
        `SP_CRIT_INSIDE: crit_met = (x < la) && (x > lb);
        `SP_CRIT_OUTSIDE: crit_met = (x > la) || (x < lb);
        `SP_CRIT_ABOVE: crit_met = (x > lb);
        `SP_CRIT_BELOW: crit_met = (x < la);
        `SP_CRIT_EQUAL: crit_met = (x == la);
        default: crit_met = 1'b0;
      endcase
    end
  endfunction

  // Masked merge of a port byte
  function [7:0] merge;
    input [7:0] cur;
    input [7:0] val;
    input [7:0] msk;
    begin
      merge = (cur & ~msk) | (val & msk);
    end
  endfunction

  // ****************************************************
  // Register bus
  // ****************************************************
  reg run_r;
  reg [15:0] hyst_hi_r;
  reg [15:0] was_true_r;
  wire [31:0] rd_mem_b;
  reg aw_hold_r;
  reg w_hold_r;
  reg [8:0] awaddr_r;
  reg [31:0] wdata_r;
  reg rd_pend_r;
  reg rd_tbl_r;
  reg [8:0] araddr_r;
  wire wr_go;
  wire wr_tbl;
  wire [5:0] ev_addr;
  reg [3:0] ev_slot_r;
  reg [1:0] ev_word_r;
  wire [31:0] mem_a_q;

  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_tbl = wr_go && awaddr_r[8];

  // Write channel capture, either order
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 9'h000;
      wdata_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      run_r <= 1'b0;
      setpoint_digital_port_oe <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        if (awaddr_r == `SP_CTRL_ADDR) begin
          run_r <= wdata_r[`SP_CTRL_RUN];
        end else if (awaddr_r == `SP_PORT_ADDR) begin
          setpoint_digital_port_oe <= 1'b1;
        end else if (!awaddr_r[8] && awaddr_r != `SP_STAT_ADDR) begin
          s_axi_bresp <= 2'b10;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: table words need one memory cycle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      rd_pend_r <= 1'b0;
      rd_tbl_r <= 1'b0;
      araddr_r <= 9'h000;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_pend_r <= 1'b1;
        araddr_r <= s_axi_araddr;
      end
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (araddr_r[8]) begin
          s_axi_rdata <= mem_a_q;
        end else if (araddr_r == `SP_CTRL_ADDR) begin
          s_axi_rdata <= {31'h0000_0000, run_r};
        end else if (araddr_r == `SP_PORT_ADDR) begin
          s_axi_rdata <= {23'h00_0000, setpoint_digital_port_oe, setpoint_digital_port_i};
        end else if (araddr_r == `SP_STAT_ADDR) begin
          s_axi_rdata <= {16'h0000, detect};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Setpoint table
  // ****************************************************
  assign ev_addr = {ev_slot_r, ev_word_r};

  setpoint_cfg_mem #(
    .AW(6),
    .DW(32)
  ) u_cfg (
    .clk_sys(clk_sys),
    .wr_en(wr_tbl),
    .wr_addr(awaddr_r[7:2]),
    .wr_data(wdata_r),
    .rd_addr_a(s_axi_arvalid && s_axi_arready ? s_axi_araddr[7:2] : araddr_r[7:2]),
    .rd_data_a(mem_a_q),
    .rd_addr_b(ev_addr),
    .rd_data_b(rd_mem_b)
  );

  // ****************************************************
  // Evaluation sequencer
  // ****************************************************
  reg [2:0] st_r;
  reg [8:0] dly_r;
  reg [15:0] x_r;
  reg [31:0] w_lim_r;
  reg [31:0] w_cfg_r;
  reg [31:0] w_v1_r;
  reg [31:0] smp_r;
  reg [8:0] dac_cnt_r;
  reg [15:0] sel_val;
  reg [7:0] sel_msk;
  reg [2:0] sel_tgt;
  reg sel_go;
  reg hit;
  reg [15:0] x_half;

  // Select the counter half
  always @* begin
    x_half = w_cfg_r[16] ? smp_r[31:16] : smp_r[15:0];
  end

  // Decision of what to apply, per mode
  always @* begin
    hit = crit_met(w_cfg_r[2:0], x_half, w_lim_r[15:0], w_lim_r[31:16]);
    sel_go = 1'b0;
    sel_val = w_v1_r[15:0];
    sel_msk = w_v1_r[23:16];
    sel_tgt = w_cfg_r[10:8];
    case (w_cfg_r[5:4])
      `SP_MODE_TRUE: begin
        sel_go = hit && !was_true_r[ev_slot_r];
      end
      `SP_MODE_TF: begin
        sel_go = 1'b1;
        if (!hit) begin
          sel_val = rd_mem_b[15:0];
          sel_msk = rd_mem_b[23:16];
          sel_tgt = w_cfg_r[14:12];
        end
      end
      `SP_MODE_HYST: begin
        if (x_half > w_lim_r[15:0]) begin
          sel_go = !hyst_hi_r[ev_slot_r];
          sel_val = rd_mem_b[15:0];
          sel_msk = rd_mem_b[23:16];
          sel_tgt = w_cfg_r[14:12];
        end else if (x_half < w_lim_r[31:16]) begin
          sel_go = hyst_hi_r[ev_slot_r] || !was_true_r[ev_slot_r];
        end
      end
      default: sel_go = 1'b0;
    endcase
  end

  // Sequencer: wait pipeline delay, fetch four words, apply
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      dly_r <= 9'd0;
      ev_slot_r <= 4'h0;
      ev_word_r <= 2'h0;
      smp_r <= 32'h0000_0000;
      w_lim_r <= 32'h0000_0000;
      w_cfg_r <= 32'h0000_0000;
      w_v1_r <= 32'h0000_0000;
      detect <= 16'h0000;
      was_true_r <= 16'h0000;
      hyst_hi_r <= 16'h0000;
      setpoint_digital_port_o <= 8'h00;
      analog_output_channel_we <= 1'b0;
      analog_output_channel_sel <= 2'h0;
      analog_output_channel_data <= 16'h0000;
      timer_load <= 1'b0;
      timer_sel <= 1'b0;
      timer_value <= 16'h0000;
    end else begin
      analog_output_channel_we <= 1'b0;
      timer_load <= 1'b0;
      if (wr_go && awaddr_r == `SP_PORT_ADDR) begin
        setpoint_digital_port_o <= wdata_r[7:0];
      end
      case (st_r)
        S_IDLE: begin
          if (run_r && smp_valid) begin
            smp_r <= smp_data;
            ev_slot_r <= smp_slot;
            dly_r <= 9'd0;
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          dly_r <= dly_r + 9'd1;
          if (dly_r == PIPE_LAST) begin
            ev_word_r <= `SP_W_LIMITS;
            st_r <= S_RD0;
          end
        end
        S_RD0: begin
          ev_word_r <= `SP_W_CFG;
          st_r <= S_RD1;
        end
        S_RD1: begin
          w_lim_r <= rd_mem_b;
          ev_word_r <= `SP_W_VAL1;
          st_r <= S_RD2;
        end
        S_RD2: begin
          w_cfg_r <= rd_mem_b;
          ev_word_r <= `SP_W_VAL2;
          st_r <= S_RD3;
        end
        S_RD3: begin
          w_v1_r <= rd_mem_b;
          st_r <= S_EVAL;
        end
        S_EVAL: begin
          detect[ev_slot_r] <= hit;
          was_true_r[ev_slot_r] <= hit;
          if (w_cfg_r[5:4] == `SP_MODE_HYST) begin
            if (x_half > w_lim_r[15:0]) begin
              hyst_hi_r[ev_slot_r] <= 1'b1;
              was_true_r[ev_slot_r] <= 1'b1;
            end else if (x_half < w_lim_r[31:16]) begin
              hyst_hi_r[ev_slot_r] <= 1'b0;
              was_true_r[ev_slot_r] <= 1'b1;
            end else begin
              was_true_r[ev_slot_r] <= was_true_r[ev_slot_r];
            end
          end
          if (sel_go) begin
            case (sel_tgt)
              `SP_TGT_PORT: begin
                setpoint_digital_port_o <=
                  merge(setpoint_digital_port_o, sel_val[7:0], sel_msk);
              end
              `SP_TGT_DAC: begin
                analog_output_channel_we <= 1'b1;
                analog_output_channel_sel <= sel_msk[1:0];
                analog_output_channel_data <= sel_val;
              end
              `SP_TGT_TIMER: begin
                timer_load <= 1'b1;
                timer_sel <= sel_msk[0];
                timer_value <= sel_val;
              end
              default: timer_load <= 1'b0;
            endcase
          end
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Analog settle timer: done pulse after shift and conversion
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      dac_cnt_r <= 9'd0;
      analog_output_channel_done <= 1'b0;
    end else begin
      analog_output_channel_done <= 1'b0;
      if (analog_output_channel_we) begin
        dac_cnt_r <= DAC_LOAD;
      end else if (dac_cnt_r != 9'd0) begin
        dac_cnt_r <= dac_cnt_r - 9'd1;
        analog_output_channel_done <= (dac_cnt_r == 9'd1);
      end
    end
  end

endmodule

// [test/setpoint_output_updater_asserts.sv]
/* Port timing checker of the setpoint updater.
   Bound from the bench; sees top ports only. */
`timescale 1ns/100ps
module setpoint_output_updater_asserts (
  input wire clk_sys,
  input wire sys_rst,
  input wire smp_valid,
  input wire setpoint_digital_port_oe,
  input wire analog_output_channel_we,
  input wire analog_output_channel_done,
  input wire timer_load,
  input wire [15:0] detect
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Analog shift plus conversion
  sequence s_conv;
    ##300 analog_output_channel_done;
  endsequence
  chk_dac_done: assert property (analog_output_channel_we |-> s_conv)
    else $error("analog done late");
  chk_done_cause: assert property (analog_output_channel_done |->
    $past(analog_output_channel_we, 300))
    else $error("analog done without write");
  chk_dac_latency: assert property (analog_output_channel_we |->
    $past(smp_valid, 203))
    else $error("analog write off latency");
  chk_timer_latency: assert property (timer_load |-> $past(smp_valid, 203))
    else $error("timer load off latency");
  chk_detect_cause: assert property ($changed(detect) |-> $past(smp_valid, 203))
    else $error("detect moved without sample");
  chk_we_pulse: assert property (analog_output_channel_we |=> !analog_output_channel_we)
    else $error("analog write too long");
  chk_load_pulse: assert property (timer_load |=> !timer_load)
    else $error("timer load too long");
  chk_oe_sticky: assert property (setpoint_digital_port_oe |=> setpoint_digital_port_oe)
    else $error("port drive dropped");
endmodule

// [test/port_partner.sv]
/* Wire model of the setpoint digital port.
   Floating pins show a moving pattern. */
`timescale 1ns/100ps
module port_partner (
  input wire clk_sys,
  input wire [7:0] port_o,
  input wire port_oe,
  output wire [7:0] pin
);
  reg [7:0] flt_r = 8'hA5;
  // Pattern while undriven
  always @(posedge clk_sys) begin
    flt_r <= ~flt_r;
  end
  assign pin = port_oe ? port_o : flt_r;
endmodule

// [test/tb_setpoint_output_updater.sv]
/* Self-checking bench of the setpoint updater.
   Needs the updater, its checker and the port partner. */
`timescale 1ns/100ps
module tb_setpoint_output_updater;
  reg clk_sys = 1'h0;
  reg sys_rst = 1'h1;
  reg [8:0] awaddr = 9'h000;
  reg [8:0] araddr = 9'h000;
  reg [31:0] wdata = 32'h0;
  reg [31:0] smp_data = 32'h0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg smp_valid = 0, scan_start = 0;
  reg [3:0] smp_slot = 4'h0;
  wire awready, wready, bvalid, arready, rvalid, oe, we, done, tl;
  wire [0:0] tsel;
  wire [1:0] bresp, rresp, sel;
  wire [31:0] rdata;
  wire [7:0] pin, port_o;
  wire [15:0] dat, tval, det;
  integer fails = 0, comparisons = 0, cyc = 0, seed = 20641;
  integer nwe = 0, nld = 0, swe = 0, sld = 0, sdn = 0, i, j, run = 0;
  reg [17:0] edac = 0, sdac = 0;
  reg [16:0] etmr = 0, stmr = 0;
  reg [7:0] eport = 0;
  reg [15:0] edet = 0, pv = 0;
  reg [31:0] cw [0:3][0:3];
  reg [31:0] crt [0:3];
  integer hs [0:3];

  always #5 clk_sys = ~clk_sys;

  setpoint_output_updater u_setpoint_output_updater (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scan_start(scan_start),
    .smp_valid(smp_valid), .smp_slot(smp_slot), .smp_data(smp_data),
    .setpoint_digital_port_i(pin), .setpoint_digital_port_o(port_o),
    .setpoint_digital_port_oe(oe), .analog_output_channel_we(we),
    .analog_output_channel_sel(sel), .analog_output_channel_data(dat),
    .analog_output_channel_done(done), .timer_load(tl), .timer_sel(tsel),
    .timer_value(tval), .detect(det));

  port_partner u_port_partner (.clk_sys(clk_sys), .port_o(port_o),
    .port_oe(oe), .pin(pin));

  // ********
  // Helpers
  // ********
  task end_of_test;
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string n, input [31:0] s, input [31:0] e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %0s expected %h seen %h", n, e, s);
    end
  endtask

  task wr(input [8:0] a, input [31:0] d, input [1:0] er);
    reg ha, hw, hb;
    reg [1:0] r;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hb = 0;
    while (!hb) begin
      @(negedge clk_sys);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    chk("bresp", r, er);
  endtask

  task rd(input [8:0] a, input [31:0] ed, input [31:0] m, input [1:0] er);
    reg ha, h;
    reg [31:0] d;
    reg [1:0] r;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    h = 0;
    while (!h) begin
      @(negedge clk_sys);
      ha = arvalid & arready;
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    chk("rresp", r, er);
    chk("rdata", d & m, ed);
  endtask

  function crit(input [2:0] c, input [15:0] x, a, b);
    case (c)
      3'h0: crit = b < x && x < a;
      3'h1: crit = x > a || x < b;
      3'h2: crit = x > b;
      3'h3: crit = x < a;
      default: crit = x == a;
    endcase
  endfunction

  task apply(input [2:0] tg, input [31:0] w);
    case (tg)
      3'h1: eport = (eport & ~w[23:16]) | (w[7:0] & w[23:16]);
      3'h2: begin nwe = nwe + 1; edac = {w[17:16], w[15:0]}; end
      3'h3: begin nld = nld + 1; etmr = {w[16], w[15:0]}; end
      default: ;
    endcase
  endtask

  // Reference behaviour of one evaluation
  task model(input integer s, input [31:0] x);
    reg [31:0] c;
    reg [15:0] v, a, b;
    reg k;
    integer t;
    c = cw[s][1];
    a = cw[s][0][15:0];
    b = cw[s][0][31:16];
    v = c[16] ? x[31:16] : x[15:0];
    k = crit(c[2:0], v, a, b);
    t = 0;
    if (c[5:4] == 2'h3) begin
      t = v > a ? 2 : (v < b ? 1 : 0);
      if (t == hs[s]) t = 0;
      else if (t > 0) hs[s] = t;
    end else if (c[5:4] == 2'h1) t = k && !pv[s] ? 1 : 0;
    else if (c[5:4] == 2'h2) t = k ? 1 : 2;
    edet[s] = k;
    pv[s] = k;
    if (t > 0) apply(c[4*t+4 +: 3], cw[s][t+1]);
  endtask

  // One sample, no analog streaming meanwhile
  task smp(input integer s, input [31:0] x);
    @(posedge clk_sys);
    smp_valid <= 1'h1;
    scan_start <= 1'h1;
    smp_slot <= s[3:0];
    smp_data <= x;
    @(posedge clk_sys);
    smp_valid <= 1'h0;
    scan_start <= 1'h0;
    if (run) model(s, x);
    repeat (210) @(posedge clk_sys);
    chk("dac count", swe, nwe);
    chk("dac", sdac, edac);
    chk("timer", {sld[14:0], stmr}, {nld[14:0], etmr});
    chk("port", port_o, eport);
    chk("detect", det, edet);
  endtask

  // Output pulse monitor and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (we) begin swe <= swe + 1; sdac <= {sel, dat}; end
    if (tl) begin sld <= sld + 1; stmr <= {tsel, tval}; end
    if (done) sdn <= sdn + 1;
    if (cyc == 20000) begin fails = fails + 1; end_of_test; end
  end

  // ********
  // Scenarios
  // ********
  initial begin
    cw[0][0] = 32'h0100_1000; cw[0][1] = 32'h0000_0210;
    cw[0][2] = 32'h0003_1357; cw[0][3] = 32'h0;
    cw[1][0] = 32'h0000_2000; cw[1][1] = 32'h0000_3123;
    cw[1][2] = 32'h003C_00F0; cw[1][3] = 32'h0001_BEEF;
    cw[2][0] = 32'h4000_8000; cw[2][1] = 32'h0000_2130;
    cw[2][2] = 32'h00FF_000F; cw[2][3] = 32'h0000_2468;
    cw[3][0] = 32'h0000_0777; cw[3][1] = 32'h0;
    cw[3][2] = 32'h0; cw[3][3] = 32'h0;
    crt[0] = 32'h1_0004; crt[1] = 32'h0_0004; crt[2] = 32'h1_0001; crt[3] = 32'h1_0002;
    for (i = 0; i < 4; i = i + 1) hs[i] = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(8'h00, 32'h0, 32'hFFFF_FFFF, 2'h0);
    rd(8'h04, 32'h0, 32'h100, 2'h0);
    rd(8'h20, 32'h0, 32'hFFFF_FFFF, 2'h2);
    wr(8'h20, 32'hFFFF, 2'h2);
    wr(8'h04, 32'h5A, 2'h0);
    eport = 8'h5A;
    rd(8'h04, 32'h15A, 32'h1FF, 2'h0);
    for (i = 0; i < 16; i = i + 1)
      wr(9'h100 + i * 4, cw[i / 4][i % 4], 2'h0);
    rd(9'h124, cw[2][1], 32'hFFFF_FFFF, 2'h0);
    smp(0, 32'h0800);
    wr(8'h00, 32'h1, 2'h0);
    run = 1;
    smp(0, 32'h0800);
    smp(0, 32'h0800);
    smp(0, 32'h1000);
    smp(0, 32'h0100);
    smp(0, 32'h0FFF);
    smp(1, 32'h1FFF);
    smp(1, 32'h2000);
    for (i = 0; i < 3; i = i + 1)
      smp(1, $random(seed) & 32'hFFFF);
    for (i = 0; i < 6; i = i + 1) begin
      j = $random(seed) & 32'h0FFF;
      smp(2, i == 2 ? 32'h8001 | j : (i % 2 && i < 5 ? 32'h5000 | j : j));
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(9'h134, crt[i], 2'h0);
      cw[3][1] = crt[i];
      smp(3, 32'h0777_0000);
    end
    rd(8'h08, {16'h0000, edet}, 32'hFFFF_FFFF, 2'h0);
    chk("dac done", sdn, nwe);
    end_of_test;
  end
endmodule

bind setpoint_output_updater setpoint_output_updater_asserts u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .smp_valid(smp_valid),
  .setpoint_digital_port_oe(setpoint_digital_port_oe),
  .analog_output_channel_we(analog_output_channel_we),
  .analog_output_channel_done(analog_output_channel_done),
  .timer_load(timer_load), .detect(detect));
